// ### follower_params.svh
`ifndef FOLLOWER_PARAMS_SVH
`define FOLLOWER_PARAMS_SVH
// Character and telegram framing.
`define CHAR_BITS 11
`define START_BYTE 8'h02
`define LEN_SHORT 8'h06
`define LEN_LONG 8'h0e
`define LEN_TEXT_FIXED 8'h0a
`define LEN_MAX 8'h1d
`define ADDR_FORMAT_BIT 7
`define ADDR_BROADCAST 7'h00
`define TEXT_INDEX_HIGH 8'h04
// Parameter command codes.
`define CMD_NONE 4'h0
`define CMD_READ 4'h1
`define CMD_WR_WORD 4'h2
`define CMD_WR_DWORD 4'h3
`define CMD_WR_EE_DWORD 4'hd
`define CMD_WR_EE_WORD 4'he
`define CMD_READ_TEXT 4'hf
// Response codes.
`define RSP_NONE 4'h0
`define RSP_WORD 4'h1
`define RSP_DWORD 4'h2
`define RSP_FAILED 4'h7
`define RSP_TEXT 4'hf
// Fault codes.
`define FAULT_ILLEGAL_PNU 8'h00
`define FAULT_NOT_CHANGEABLE 8'h01
`define FAULT_LIMIT 8'h02
`define FAULT_SUBINDEX 8'h03
`define FAULT_NO_ARRAY 8'h04
`define FAULT_DATA_TYPE 8'h05
`define FAULT_NO_WRITE 8'h0b
`define FAULT_RUNNING 8'h11
`define FAULT_OTHER 8'h12
`define FAULT_NO_BUS 8'h82
`define FAULT_UNSUPPORTED 8'hfd
`define FAULT_NONE 8'hff
// Response buffering.
`define FIFO_DEPTH 16
`endif

// ### follower_pkg.sv
package follower_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_COLLECT = 3'b001,
        ST_EXEC = 3'b011,
        ST_HOLD = 3'b010,
        ST_BUILD = 3'b110,
        ST_DRAIN = 3'b100
    } state_t;
endpackage

// ### telegram_follower.sv
// What this block does
// - Character is start bit, eight data bits, parity bit, stop bit: eleven bits.
// - Parity makes the ones in data plus parity even; odd count is flagged.
// - Telegram is start byte 02, length, address, data bytes, check byte.
// - Length byte counts data bytes plus address and check byte.
// - Text telegram length is ten fixed bytes plus the text characters.
// - Address bit 7 selects format; bits 6..0 give address, zero is broadcast.
// - The reply carries the received address byte unchanged.
// - Check byte is a running XOR starting from zero each telegram.
// - The follower transmits only in answer to a request; half duplex link.
// - Formats are 8-byte short, 16-byte long with parameters, and text.
// - Process block is two words: control/reference in, status/frequency out.
// - Parameter data area is twelve bytes: parameter fields then process words.
// - Key word holds command or response in 15..12, parameter number in 11..0.
// - The follower encodes the listed response codes.
// - A command that cannot run gets response 0111 plus a fault code.
// - Fault codes follow the listed numeric table.
// - Index word is high then low byte; only the low byte selects the element.
// - Value field is four bytes; a read returns the current parameter value.
// - Text telegram length comes from the length byte; index tells read or write.
// - The reply waits at least the configured minimum delay after the request.
// - A gap between bytes above the configured maximum abandons the telegram.
`timescale 1ns/1ps
`default_nettype none
`include "follower_params.svh"

module resp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != DEPTH[AW:0]);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // resp_fifo

module telegram_follower
    import follower_pkg::*;
(
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Configuration.
    input wire logic [6:0] OWN_ADDR,
    input wire logic [15:0] BIT_CYCLES,
    input wire logic [15:0] MIN_RESP_CYCLES,
    input wire logic [23:0] MAX_GAP_CYCLES,
    // Serial line.
    input wire logic RXD,
    output logic TXD,
    output logic TX_ACTIVE,
    // Process data.
    output logic PROCESS_VALID,
    output logic [15:0] CONTROL_WORD,
    output logic [15:0] REFERENCE_WORD,
    input wire logic [15:0] STATUS_WORD,
    input wire logic [15:0] OUTPUT_FREQ,
    // Parameter channel.
    output logic PAR_REQ,
    output logic [3:0] PAR_COMMAND,
    output logic [11:0] PAR_NUMBER,
    output logic [7:0] PAR_INDEX,
    output logic [31:0] PAR_WVALUE,
    input wire logic PAR_DONE,
    input wire logic PAR_FAIL,
    input wire logic [7:0] PAR_FAULT,
    input wire logic PAR_DOUBLE,
    input wire logic [31:0] PAR_RVALUE,
    // Error events.
    output logic FRAME_ERROR,
    output logic CHECK_ERROR,
    output logic GAP_TIMEOUT
);
    state_t state_r;
    byte_t rx_buf [0:31];
    logic rx_busy_r, rx_stb_r, rx_bad_r;
    logic [15:0] rx_cnt_r;
    logic [3:0] rx_bit_r;
    logic [8:0] rx_sh_r;
    byte_t rx_byte_r;
    logic [4:0] rx_idx_r;
    byte_t rx_xor_r, rx_len_r;
    logic [23:0] gap_r;
    logic [15:0] hold_r;
    logic bcast_r, req_sent_r;
    logic [3:0] rsp_code_r;
    logic [31:0] rsp_value_r;
    byte_t resp_len_r, tx_xor_r, bld_byte;
    logic [4:0] bld_idx_r;
    logic fifo_in_ready, fifo_out_valid, tx_pop;
    byte_t fifo_out_data;
    logic tx_busy_r;
    logic [15:0] tx_cnt_r;
    logic [3:0] tx_bit_r;
    logic [10:0] tx_sh_r;
    logic bld_push, long_req, last_byte;
    logic [3:0] req_cmd;
    logic [4:0] lp;
    logic need_req, tel_ok;

    assign lp = rx_len_r[4:0];
    assign long_req = (rx_len_r != `LEN_SHORT);
    assign req_cmd = rx_buf[3][7:4];
    assign bld_push = (state_r == ST_BUILD) && fifo_in_ready;
    assign last_byte = (bld_idx_r == 5'(resp_len_r + 8'h01));
    assign need_req = (req_cmd == `CMD_READ) || (req_cmd == `CMD_WR_WORD) || (req_cmd == `CMD_WR_DWORD)
        || (req_cmd == `CMD_WR_EE_DWORD) || (req_cmd == `CMD_WR_EE_WORD)
        || (req_cmd == `CMD_READ_TEXT && rx_buf[5] == `TEXT_INDEX_HIGH);
    // Only a complete, clean telegram for this follower may touch the process words.
    assign tel_ok = state_r == ST_COLLECT && rx_stb_r && !rx_bad_r && rx_idx_r == 5'(rx_len_r + 8'h01)
        && rx_xor_r == rx_byte_r && rx_buf[2][`ADDR_FORMAT_BIT]
        && (rx_buf[2][6:0] == OWN_ADDR || rx_buf[2][6:0] == `ADDR_BROADCAST);

    // Receive character: start, 8 data LSB first, parity, stop.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 16'h0000;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 9'h000;
            rx_stb_r <= 1'b0;
            rx_bad_r <= 1'b0;
            rx_byte_r <= 8'h00;
        end else begin
            rx_stb_r <= 1'b0;
            if (!rx_busy_r) begin
                if (!RXD && !TX_ACTIVE) begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r <= BIT_CYCLES >> 1;
                    rx_bit_r <= 4'h0;
                end
            end else if (rx_cnt_r != 16'h0000) begin
                rx_cnt_r <= rx_cnt_r - 16'h0001;
            end else begin
                rx_cnt_r <= BIT_CYCLES - 16'h0001;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && RXD) begin
                    rx_busy_r <= 1'b0;
                end else if (rx_bit_r == 4'(`CHAR_BITS - 1)) begin
                    rx_busy_r <= 1'b0;
                    rx_stb_r <= 1'b1;
                    rx_byte_r <= rx_sh_r[7:0];
                    rx_bad_r <= !RXD || (^rx_sh_r);
                end else if (rx_bit_r != 4'h0) begin
                    rx_sh_r <= {RXD, rx_sh_r[8:1]};
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (rx_stb_r && state_r == ST_COLLECT) begin
            rx_buf[rx_idx_r] <= rx_byte_r;
        end
    end

    // Telegram sequencing.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= ST_IDLE;
            rx_idx_r <= 5'h00;
            rx_xor_r <= 8'h00;
            rx_len_r <= `LEN_SHORT;
            gap_r <= 24'h000000;
            hold_r <= 16'h0000;
            bcast_r <= 1'b0;
            FRAME_ERROR <= 1'b0;
            CHECK_ERROR <= 1'b0;
            GAP_TIMEOUT <= 1'b0;
        end else begin
            FRAME_ERROR <= 1'b0;
            CHECK_ERROR <= 1'b0;
            GAP_TIMEOUT <= 1'b0;
            if (hold_r != 16'hffff) begin
                hold_r <= hold_r + 16'h0001;
            end
            unique case (state_r)
                ST_IDLE: begin
                    if (rx_stb_r && !rx_bad_r && rx_byte_r == `START_BYTE) begin
                        state_r <= ST_COLLECT;
                        rx_idx_r <= 5'h01;
                        rx_xor_r <= `START_BYTE;
                        gap_r <= 24'h000000;
                    end
                end
                ST_COLLECT: begin
                    gap_r <= gap_r + 24'h000001;
                    if (rx_stb_r) begin
                        gap_r <= 24'h000000;
                        rx_idx_r <= rx_idx_r + 5'h01;
                        rx_xor_r <= rx_xor_r ^ rx_byte_r;
                        if (rx_bad_r) begin
                            state_r <= ST_IDLE;
                            FRAME_ERROR <= 1'b1;
                        end else if (rx_idx_r == 5'h01) begin
                            rx_len_r <= rx_byte_r;
                            if (rx_byte_r < `LEN_SHORT || rx_byte_r > `LEN_MAX) begin
                                state_r <= ST_IDLE;
                            end
                        end else if (rx_idx_r == 5'(rx_len_r + 8'h01)) begin
                            hold_r <= 16'h0000;
                            bcast_r <= (rx_buf[2][6:0] == `ADDR_BROADCAST);
                            if (rx_xor_r != rx_byte_r) begin
                                state_r <= ST_IDLE;
                                CHECK_ERROR <= 1'b1;
                            end else if (rx_buf[2][`ADDR_FORMAT_BIT] && (rx_buf[2][6:0] == OWN_ADDR
                                    || rx_buf[2][6:0] == `ADDR_BROADCAST)) begin
                                state_r <= ST_EXEC;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end else if (gap_r >= MAX_GAP_CYCLES) begin
                        state_r <= ST_IDLE;
                        GAP_TIMEOUT <= 1'b1;
                    end
                end
                ST_EXEC: begin
                    if (!long_req || !need_req || (req_sent_r && PAR_DONE)) begin
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (bcast_r) begin
                        state_r <= ST_IDLE;
                    end else if (hold_r >= MIN_RESP_CYCLES) begin
                        state_r <= ST_BUILD;
                    end
                end
                ST_BUILD: begin
                    if (bld_push && last_byte) begin
                        state_r <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (!fifo_out_valid && !tx_busy_r) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Parameter channel decode and answer.
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            req_sent_r <= 1'b0;
            PAR_REQ <= 1'b0;
            PAR_COMMAND <= `CMD_NONE;
            PAR_NUMBER <= 12'h000;
            PAR_INDEX <= 8'h00;
            PAR_WVALUE <= 32'h00000000;
            PROCESS_VALID <= 1'b0;
            CONTROL_WORD <= 16'h0000;
            REFERENCE_WORD <= 16'h0000;
            rsp_code_r <= `RSP_NONE;
            rsp_value_r <= 32'h00000000;
            resp_len_r <= `LEN_SHORT;
        end else begin
            PAR_REQ <= 1'b0;
            PROCESS_VALID <= 1'b0;
            if (tel_ok) begin
                req_sent_r <= 1'b0;
                rsp_code_r <= `RSP_NONE;
                rsp_value_r <= 32'h00000000;
                resp_len_r <= long_req ? `LEN_LONG : `LEN_SHORT;
                CONTROL_WORD <= {rx_buf[lp - 5'd3], rx_buf[lp - 5'd2]};
                REFERENCE_WORD <= {rx_buf[lp - 5'd1], rx_buf[lp]};
                PROCESS_VALID <= 1'b1;
            end
            if (state_r == ST_EXEC && long_req && !req_sent_r && !PAR_REQ) begin
                req_sent_r <= 1'b1;
                PAR_COMMAND <= req_cmd;
                PAR_NUMBER <= {rx_buf[3][3:0], rx_buf[4]};
                PAR_INDEX <= rx_buf[6];
                PAR_WVALUE <= {rx_buf[7], rx_buf[8], rx_buf[9], rx_buf[10]};
                unique case (req_cmd)
                    `CMD_NONE: req_sent_r <= 1'b0;
                    `CMD_READ, `CMD_WR_WORD, `CMD_WR_DWORD, `CMD_WR_EE_DWORD, `CMD_WR_EE_WORD: PAR_REQ <= 1'b1;
                    `CMD_READ_TEXT: begin
                        if (rx_buf[5] == `TEXT_INDEX_HIGH) begin
                            PAR_REQ <= 1'b1;
                        end else begin
                            req_sent_r <= 1'b0;
                            rsp_code_r <= `RSP_FAILED;
                            rsp_value_r <= {24'h000000, `FAULT_UNSUPPORTED};
                        end
                    end
                    default: begin
                        req_sent_r <= 1'b0;
                        rsp_code_r <= `RSP_FAILED;
                        rsp_value_r <= {24'h000000, `FAULT_UNSUPPORTED};
                    end
                endcase
            end
            if (state_r == ST_EXEC && req_sent_r && PAR_DONE) begin
                req_sent_r <= 1'b0;
                if (PAR_FAIL) begin
                    rsp_code_r <= `RSP_FAILED;
                    rsp_value_r <= {24'h000000, PAR_FAULT};
                end else begin
                    rsp_value_r <= PAR_RVALUE;
                    if (PAR_COMMAND == `CMD_READ_TEXT) begin
                        rsp_code_r <= `RSP_TEXT;
                    end else begin
                        rsp_code_r <= PAR_DOUBLE ? `RSP_DWORD : `RSP_WORD;
                    end
                end
            end
        end
    end

    // Reply byte selection; short replies map onto the process slots of the long layout.
    always_comb begin
        logic [4:0] k;
        k = (resp_len_r == `LEN_SHORT && bld_idx_r >= 5'd3) ? bld_idx_r + 5'd8 : bld_idx_r;
        if (last_byte) begin
            bld_byte = tx_xor_r;
        end else begin
            unique case (k)
                5'd0: bld_byte = `START_BYTE;
                5'd1: bld_byte = resp_len_r;
                5'd2: bld_byte = rx_buf[2];
                5'd3: bld_byte = {rsp_code_r, PAR_NUMBER[11:8]};
                5'd4: bld_byte = PAR_NUMBER[7:0];
                5'd5: bld_byte = rx_buf[5];
                5'd6: bld_byte = rx_buf[6];
                5'd7: bld_byte = rsp_value_r[31:24];
                5'd8: bld_byte = rsp_value_r[23:16];
                5'd9: bld_byte = rsp_value_r[15:8];
                5'd10: bld_byte = rsp_value_r[7:0];
                5'd11: bld_byte = STATUS_WORD[15:8];
                5'd12: bld_byte = STATUS_WORD[7:0];
                5'd13: bld_byte = OUTPUT_FREQ[15:8];
                default: bld_byte = OUTPUT_FREQ[7:0];
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            bld_idx_r <= 5'h00;
            tx_xor_r <= 8'h00;
        end else if (state_r != ST_BUILD) begin
            bld_idx_r <= 5'h00;
            tx_xor_r <= 8'h00;
        end else if (bld_push) begin
            bld_idx_r <= bld_idx_r + 5'h01;
            tx_xor_r <= tx_xor_r ^ bld_byte;
        end
    end

    resp_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .in_valid(bld_push),
        .in_ready(fifo_in_ready),
        .in_data(bld_byte),
        .out_valid(fifo_out_valid),
        .out_ready(tx_pop),
        .out_data(fifo_out_data)
    );

    // Transmit character; the FIFO holds built bytes while a character is on the line.
    assign tx_pop = fifo_out_valid && !tx_busy_r;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tx_busy_r <= 1'b0;
            tx_cnt_r <= 16'h0000;
            tx_bit_r <= 4'h0;
            tx_sh_r <= 11'h7ff;
            TXD <= 1'b1;
            TX_ACTIVE <= 1'b0;
        end else begin
            TX_ACTIVE <= (state_r == ST_BUILD) || (state_r == ST_DRAIN);
            if (tx_pop) begin
                tx_busy_r <= 1'b1;
                tx_sh_r <= {1'b1, ^fifo_out_data, fifo_out_data, 1'b0};
                tx_bit_r <= 4'(`CHAR_BITS);
                tx_cnt_r <= 16'h0000;
            end else if (tx_busy_r) begin
                if (tx_cnt_r != 16'h0000) begin
                    tx_cnt_r <= tx_cnt_r - 16'h0001;
                end else if (tx_bit_r == 4'h0) begin
                    tx_busy_r <= 1'b0;
                end else begin
                    TXD <= tx_sh_r[0];
                    tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                    tx_bit_r <= tx_bit_r - 4'h1;
                    tx_cnt_r <= BIT_CYCLES - 16'h0001;
                end
            end else begin
                TXD <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    a_tx_only_reply: assert property ($rose(TX_ACTIVE) |-> $past(state_r, 2) == ST_HOLD && !bcast_r)
        else $error("transmit started without a request");
    a_start_byte: assert property (bld_push && bld_idx_r == 5'd0 |-> bld_byte == `START_BYTE)
        else $error("reply does not open with the start byte");
    a_length_byte: assert property (bld_push && bld_idx_r == 5'd1 |-> bld_byte == resp_len_r
            && (resp_len_r == `LEN_SHORT || resp_len_r == `LEN_LONG))
        else $error("reply length byte wrong");
    a_addr_echo: assert property (bld_push && bld_idx_r == 5'd2 |-> bld_byte == rx_buf[2])
        else $error("reply address differs from request");
    a_check_byte: assert property (bld_push && last_byte |=> state_r == ST_DRAIN && $past(bld_byte) == $past(tx_xor_r))
        else $error("reply check byte wrong");
    a_char_frame: assert property (tx_pop |=> tx_sh_r[0] == 1'b0 && tx_sh_r[10] == 1'b1 && tx_bit_r == 4'd11)
        else $error("character frame malformed");
    a_even_parity: assert property (tx_pop |=> ^tx_sh_r[9:1] == 1'b0)
        else $error("parity not even");
    a_fault_report: assert property (state_r == ST_EXEC && req_sent_r && PAR_DONE && PAR_FAIL
            |=> rsp_code_r == `RSP_FAILED && rsp_value_r[7:0] == $past(PAR_FAULT) && state_r == ST_HOLD)
        else $error("failure not reported with fault code");
    a_min_delay: assert property (state_r == ST_HOLD ##1 state_r == ST_BUILD |-> $past(hold_r) >= $past(MIN_RESP_CYCLES))
        else $error("reply started before minimum delay");
    a_gap_abandon: assert property (GAP_TIMEOUT |-> state_r == ST_IDLE && !$past(rx_stb_r))
        else $error("gap timeout left telegram open");

    c_long_reply: cover property (bld_push && last_byte && resp_len_r == `LEN_LONG);
    c_short_reply: cover property (bld_push && last_byte && resp_len_r == `LEN_SHORT);
    c_fault_reply: cover property (state_r == ST_BUILD && rsp_code_r == `RSP_FAILED);
    c_gap_timeout: cover property (GAP_TIMEOUT);
endmodule // telegram_follower
`default_nettype wire

// ### fb_master.sv
`timescale 1ns/1ps
`default_nettype none
module fb_master (
    // Clock and serial line.
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    logic [7:0] rx_q[$];
    logic [9:0] f;
    logic bad = 1'b0;
    int flip = -1;
    int gap = 0;
    int par_bad = 0;
    initial rxd = 1'b1;
    task automatic put(input logic [7:0] b, input logic inv);
        logic [10:0] c;
        c = {1'b1, (^b) ^ inv, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd = c[i];
            repeat (8) @(posedge clk);
            #1;
        end
    endtask
    task automatic send(input logic [119:0] t, input int n);
        logic [7:0] x;
        x = 8'h00;
        for (int i = 0; i < n; i++) begin
            put(t[8 * (n - 1 - i) +: 8], i == flip);
            x = x ^ t[8 * (n - 1 - i) +: 8];
            #(8 * gap);
        end
        put(x ^ {7'h00, bad}, 1'b0);
    endtask
    // Samples each reply bit near its middle, clear of the clock edges.
    always begin
        @(negedge txd);
        #34;
        for (int i = 0; i < 10; i++) begin
            #64;
            f[i] = txd;
        end
        if ((^f[8:0]) !== 1'b0 || f[9] !== 1'b1) par_bad++;
        rx_q.push_back(f[7:0]);
    end
endmodule // fb_master
`default_nettype wire

// ### tb_telegram_follower.sv
`timescale 1ns/1ps
`default_nettype none
module tb_telegram_follower;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic rxd, txd, tx_active, pv, par_req, fe, ce, gto;
    logic par_done = 1'b0;
    logic par_fail = 1'b0;
    logic par_double = 1'b0;
    logic [7:0] par_fault = 8'h00;
    logic [31:0] par_rvalue = 32'h0;
    logic [15:0] stat = 16'ha55a;
    logic [15:0] cw, rw;
    logic [3:0] pcmd, c, r;
    logic [11:0] pnum;
    logic [7:0] pidx;
    logic [31:0] pwv;
    int err_total = 0;
    int check_count = 0;
    int n_pv = 0, n_req = 0, n_fe = 0, n_ce = 0, n_gto = 0, tn = 0, k;
    always #4 sys_clk = ~sys_clk;
    fb_master m (.clk(sys_clk), .txd(txd), .rxd(rxd));
    telegram_follower uut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .OWN_ADDR(7'h05), .BIT_CYCLES(16'h0008),
        .MIN_RESP_CYCLES(16'h0014), .MAX_GAP_CYCLES(24'h0000c8), .RXD(rxd), .TXD(txd), .TX_ACTIVE(tx_active),
        .PROCESS_VALID(pv), .CONTROL_WORD(cw), .REFERENCE_WORD(rw), .STATUS_WORD(stat),
        .OUTPUT_FREQ(16'h0123), .PAR_REQ(par_req), .PAR_COMMAND(pcmd), .PAR_NUMBER(pnum), .PAR_INDEX(pidx),
        .PAR_WVALUE(pwv), .PAR_DONE(par_done), .PAR_FAIL(par_fail), .PAR_FAULT(par_fault),
        .PAR_DOUBLE(par_double), .PAR_RVALUE(par_rvalue), .FRAME_ERROR(fe), .CHECK_ERROR(ce), .GAP_TIMEOUT(gto));
    always @(posedge sys_clk) begin
        if (pv === 1'b1) n_pv++;
        if (fe === 1'b1) n_fe++;
        if (ce === 1'b1) n_ce++;
        if (gto === 1'b1) n_gto++;
    end
    // Parameter store answers three cycles after each request.
    always begin
        @(posedge sys_clk iff par_req === 1'b1);
        n_req++;
        repeat (3) @(posedge sys_clk);
        #1 par_done = 1'b1;
        @(posedge sys_clk);
        #1 par_done = 1'b0;
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic run(input logic [119:0] t, input int n, input logic [95:0] e, input int ne, input int nr);
        int first;
        logic [7:0] x;
        first = -1;
        x = 8'h00;
        m.rx_q.delete();
        m.send(t, n);
        for (int i = 0; i < 4000; i++) begin
            @(posedge sys_clk);
            if (tx_active === 1'b1 && first < 0) first = i;
            if (first >= 0 && tx_active === 1'b0) break;
        end
        #1;
        cmp(m.rx_q.size(), nr);
        for (int i = 0; i < 3 && nr > 0; i++) cmp(m.rx_q[i], t[8 * (n - 1 - i) +: 8]);
        for (int i = 0; i < ne; i++) cmp(m.rx_q[i + 3], e[8 * (nr - 5 - i) +: 8]);
        foreach (m.rx_q[i]) x = x ^ m.rx_q[i];
        cmp(x, 0);
        if (nr > 0) cmp(first + 2 >= 20, 1);
        $display("test %0d done", tn++);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #600000;
        err_total++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        run(120'h02068512345678, 7, 96'ha55a0123, 4, 8);
        cmp({cw, rw}, 32'h12345678);
        cmp(n_pv, 1);
        par_rvalue = 32'h000003e8;
        run(120'h020e85115500000000000000010002, 15, 96'h11550000000003e8a55a0123, 12, 16);
        par_fail = 1'b1;
        par_fault = 8'h11;
        run(120'h020e85e19e0007000003e800010002, 15, 96'h719e000700000011a55a0123, 12, 16);
        cmp({pcmd, pnum, pidx}, {4'he, 12'h19e, 8'h07});
        cmp(pwv, 32'h000003e8);
        par_fail = 1'b0;
        par_double = 1'b1;
        for (int i = 0; i < 7; i++) begin
            c = 4'(28'h0234def >> (4 * (6 - i)));
            r = 4'(28'h022722f >> (4 * (6 - i)));
            k = n_req;
            run({24'h020e85, c, 12'h155, (c == 4'hf) ? 16'h0400 : 16'h0000, 64'h1}, 15,
                {r, 12'h155, (c == 4'hf) ? 16'h0400 : 16'h0000, (r == 4'h7) ? 32'hfd : par_rvalue, 32'ha55a0123},
                (r == 4'h0) ? 2 : 12, 16);
            cmp(n_req - k, (r == 4'h0 || r == 4'h7) ? 0 : 1);
        end
        m.bad = 1'b1;
        run(120'h02068512345678, 7, 96'h0, 0, 0);
        m.bad = 1'b0;
        cmp(n_ce, 1);
        run(120'h02068011112222, 7, 96'h0, 0, 0);
        run(120'h02068633334444, 7, 96'h0, 0, 0);
        run(120'h02060533334444, 7, 96'h0, 0, 0);
        cmp({cw, rw}, 32'h11112222);
        m.flip = 4;
        run(120'h02068533334444, 7, 96'h0, 0, 0);
        m.flip = -1;
        cmp(n_fe, 1);
        m.gap = 150;
        run(120'h02068512345678, 7, 96'h0, 0, 0);
        m.gap = 0;
        cmp(n_gto, 1);
        cmp(m.par_bad, 0);
        end_sim;
    end
endmodule // tb_telegram_follower
`default_nettype wire
